// [include/sbpr_pkg.sv]
// constants of the basic parameter table slice, bytes 0Ch to 23h
package sbpr_pkg;
   localparam int ADDR_W = 12;
   localparam int WORD_W = 32;
   localparam int BYTE_W = 8;
   // table base in the discoverable parameter space
   localparam logic [11:0] TABLE_BASE = 12'h340;
   // relative span covered by this block, word aligned
   localparam logic [7:0] REL_FIRST = 8'h0C;
   localparam logic [7:0] REL_LAST = 8'h23;
   localparam logic [7:0] OUT_OF_SPAN = 8'h00;
   // relative byte offsets inside the span
   localparam logic [7:0] REL_DUAL_OUT_CYC = 8'h0C;
   localparam logic [7:0] REL_DUAL_OUT_CMD = 8'h0D;
   localparam logic [7:0] REL_DUAL_IO_CYC = 8'h0E;
   localparam logic [7:0] REL_DUAL_IO_CMD = 8'h0F;
   localparam logic [7:0] REL_PROTO_SUPPORT = 8'h10;
   localparam logic [7:0] REL_RESERVED_0 = 8'h11;
   localparam logic [7:0] REL_RESERVED_1 = 8'h12;
   localparam logic [7:0] REL_RESERVED_2 = 8'h13;
   localparam logic [7:0] REL_RESERVED_3 = 8'h14;
   localparam logic [7:0] REL_RESERVED_4 = 8'h15;
   localparam logic [7:0] REL_DUAL_ALL_CYC = 8'h16;
   localparam logic [7:0] REL_DUAL_ALL_CMD = 8'h17;
   localparam logic [7:0] REL_RESERVED_5 = 8'h18;
   localparam logic [7:0] REL_RESERVED_6 = 8'h19;
   localparam logic [7:0] REL_QUAD_ALL_CYC = 8'h1A;
   localparam logic [7:0] REL_QUAD_ALL_CMD = 8'h1B;
   localparam logic [7:0] REL_ERASE1_EXP = 8'h1C;
   localparam logic [7:0] REL_ERASE1_CMD = 8'h1D;
   localparam logic [7:0] REL_ERASE2_EXP = 8'h1E;
   localparam logic [7:0] REL_ERASE2_CMD = 8'h1F;
   localparam logic [7:0] REL_ERASE3_EXP = 8'h20;
   localparam logic [7:0] REL_ERASE3_CMD = 8'h21;
   localparam logic [7:0] REL_ERASE4_EXP = 8'h22;
   localparam logic [7:0] REL_ERASE4_CMD = 8'h23;
   // byte values
   localparam logic [7:0] B_DUAL_OUT_CYC = 8'h08;
   localparam logic [7:0] B_DUAL_OUT_CMD = 8'h3B;
   localparam logic [7:0] B_DUAL_IO_CYC = 8'h88;
   localparam logic [7:0] B_DUAL_IO_CMD = 8'hBB;
   localparam logic [7:0] B_PROTO_SUPPORT = 8'hFE;
   localparam logic [7:0] B_RESERVED_FUTURE = 8'hFF;
   localparam logic [7:0] B_DUAL_ALL_CYC = 8'hFF;
   localparam logic [7:0] B_DUAL_ALL_CMD = 8'hFF;
   localparam logic [7:0] B_QUAD_ALL_CYC = 8'h48;
   localparam logic [7:0] B_QUAD_ALL_CMD = 8'hEB;
   localparam logic [7:0] B_ERASE1_EXP = 8'h0C;
   localparam logic [7:0] B_ERASE1_CMD = 8'h20;
   localparam logic [7:0] B_ERASE2_EXP = 8'h0F;
   localparam logic [7:0] B_ERASE2_CMD = 8'h52;
   localparam logic [7:0] B_ERASE3_EXP = 8'h10;
   localparam logic [7:0] B_ERASE3_CMD = 8'hD8;
   localparam logic [7:0] B_ERASE4_EXP = 8'h00;
   localparam logic [7:0] B_ERASE4_CMD = 8'hFF;
   // field positions inside the protocol support byte
   localparam int QUAD_ALL_BIT = 4;
   localparam int DUAL_ALL_BIT = 0;
endpackage

// [src/sbpr_rom.sv]
// read-only basic parameter table slice with byte and word read ports
`timescale 1ns/1ps
module sbpr_rom (
   input  wire logic                         clk_sys_i,
   input  wire logic                         rst_i,
   input  wire logic                         rd_req_i,
   input  wire logic [sbpr_pkg::ADDR_W-1:0]  rd_addr_i,
   output logic                              rd_valid_o,
   output logic                              rd_hit_o,
   output logic [sbpr_pkg::BYTE_W-1:0]       rd_byte_o,
   output logic [sbpr_pkg::WORD_W-1:0]       rd_word_o
);

   // ----------------------------------------
   // address decode
   // ----------------------------------------
   // relative address from the table base
   wire logic [sbpr_pkg::ADDR_W-1:0] rel_full;
   wire logic [7:0]                  rel;
   wire logic                        in_span;
   wire logic [7:0]                  word_base;
   assign rel_full = rd_addr_i - sbpr_pkg::TABLE_BASE;
   assign rel = rel_full[7:0];
   assign in_span = (rd_addr_i >= sbpr_pkg::TABLE_BASE)
                  && (rel_full[sbpr_pkg::ADDR_W-1:8] == '0)
                  && (rel >= sbpr_pkg::REL_FIRST)
                  && (rel <= sbpr_pkg::REL_LAST);
   assign word_base = {rel[7:2], 2'b00};

   // ----------------------------------------
   // constant table lookup
   // ----------------------------------------
   function automatic logic [7:0] sbpr_lookup(input logic [7:0] a);
      logic [7:0] v;
      v = sbpr_pkg::OUT_OF_SPAN;
      unique case (a)
         sbpr_pkg::REL_DUAL_OUT_CYC: v = sbpr_pkg::B_DUAL_OUT_CYC;
         sbpr_pkg::REL_DUAL_OUT_CMD: v = sbpr_pkg::B_DUAL_OUT_CMD;
         sbpr_pkg::REL_DUAL_IO_CYC: v = sbpr_pkg::B_DUAL_IO_CYC;
         sbpr_pkg::REL_DUAL_IO_CMD: v = sbpr_pkg::B_DUAL_IO_CMD;
         sbpr_pkg::REL_PROTO_SUPPORT: v = sbpr_pkg::B_PROTO_SUPPORT;
         sbpr_pkg::REL_RESERVED_0, sbpr_pkg::REL_RESERVED_1,
         sbpr_pkg::REL_RESERVED_2, sbpr_pkg::REL_RESERVED_3,
         sbpr_pkg::REL_RESERVED_4, sbpr_pkg::REL_RESERVED_5,
         sbpr_pkg::REL_RESERVED_6: v = sbpr_pkg::B_RESERVED_FUTURE;
         sbpr_pkg::REL_DUAL_ALL_CYC: v = sbpr_pkg::B_DUAL_ALL_CYC;
         sbpr_pkg::REL_DUAL_ALL_CMD: v = sbpr_pkg::B_DUAL_ALL_CMD;
         sbpr_pkg::REL_QUAD_ALL_CYC: v = sbpr_pkg::B_QUAD_ALL_CYC;
         sbpr_pkg::REL_QUAD_ALL_CMD: v = sbpr_pkg::B_QUAD_ALL_CMD;
         // sizes are exponents of the byte count
         sbpr_pkg::REL_ERASE1_EXP: v = sbpr_pkg::B_ERASE1_EXP;
         sbpr_pkg::REL_ERASE1_CMD: v = sbpr_pkg::B_ERASE1_CMD;
         sbpr_pkg::REL_ERASE2_EXP: v = sbpr_pkg::B_ERASE2_EXP;
         sbpr_pkg::REL_ERASE2_CMD: v = sbpr_pkg::B_ERASE2_CMD;
         sbpr_pkg::REL_ERASE3_EXP: v = sbpr_pkg::B_ERASE3_EXP;
         sbpr_pkg::REL_ERASE3_CMD: v = sbpr_pkg::B_ERASE3_CMD;
         sbpr_pkg::REL_ERASE4_EXP: v = sbpr_pkg::B_ERASE4_EXP;
         sbpr_pkg::REL_ERASE4_CMD: v = sbpr_pkg::B_ERASE4_CMD;
         default: v = sbpr_pkg::OUT_OF_SPAN;
      endcase
      return v;
   endfunction

   // ----------------------------------------
   // byte and word selection
   // ----------------------------------------
   wire logic [7:0]  next_byte;
   wire logic [31:0] next_word;
   assign next_byte = in_span ? sbpr_lookup(rel) : sbpr_pkg::OUT_OF_SPAN;
   // lowest address in bits 7:0
   localparam int LANES = sbpr_pkg::WORD_W / sbpr_pkg::BYTE_W;
   genvar gi;
   generate
      for (gi = 0; gi < LANES; gi++) begin : g_lane
         assign next_word[gi*sbpr_pkg::BYTE_W +: sbpr_pkg::BYTE_W] = in_span
            ? sbpr_lookup(word_base + 8'(gi)) : sbpr_pkg::OUT_OF_SPAN;
      end
   endgenerate

   // ----------------------------------------
   // registered answer, one cycle after request
   // ----------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         rd_valid_o <= 1'b0;
         rd_hit_o   <= 1'b0;
         rd_byte_o  <= '0;
         rd_word_o  <= '0;
      end else begin
         rd_valid_o <= rd_req_i;
         if (rd_req_i) begin
            rd_hit_o  <= in_span;
            rd_byte_o <= next_byte;
            rd_word_o <= next_word;
         end
      end
   end

   // ----------------------------------------
   // checks on the answer timing
   // ----------------------------------------
   // valid rises the cycle after every request
   a_valid_follows: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      rd_req_i |=> rd_valid_o ##1 ($past(rd_req_i) == rd_valid_o))
      else $error("valid does not follow request");
   // held answer does not move without a request
   a_hold_idle: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      !rd_req_i |=> !rd_valid_o && $stable(rd_byte_o)
      && $stable(rd_word_o) && $stable(rd_hit_o))
      else $error("answer moved without request");
   // reset clears every output by the next edge
   a_reset_clear: assert property (
      @(posedge clk_sys_i)
      rst_i |=> !rd_valid_o && !rd_hit_o && rd_byte_o == 8'h00
      && rd_word_o == 32'h00000000)
      else $error("outputs not cleared by reset");

   // ----------------------------------------
   // checks on single table bytes, some through the word port
   // ----------------------------------------
   // read instruction bytes and their cycle fields
   a_dual_out_cyc: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      rd_req_i && rd_addr_i == 12'h34C
      |=> rd_byte_o[7:5] == 3'b000 && rd_byte_o[4:0] == 5'b01000)
      else $error("dual out cycle fields wrong");
   a_dual_out_code: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      rd_req_i && rd_addr_i == 12'h34D |=> rd_byte_o == 8'h3B)
      else $error("dual out code wrong");
   a_dual_io_byte: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      rd_req_i && rd_addr_i == 12'h34E |=> rd_byte_o == 8'h88)
      else $error("dual io cycles byte wrong");
   a_dual_io_code: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      rd_req_i && rd_addr_i == 12'h34F |=> rd_byte_o == 8'hBB)
      else $error("dual io code wrong");
   a_quad_all_flag: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      rd_req_i && rd_addr_i == 12'h350 |=> rd_byte_o[4] && !rd_byte_o[0])
      else $error("protocol support byte wrong");
   a_proto_byte: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      rd_req_i && rd_addr_i == 12'h350 |=> rd_byte_o == 8'hFE)
      else $error("protocol support reserved bits wrong");
   // reserved and unsupported bytes read all ones
   a_reserved_ones: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      rd_req_i && rd_addr_i == 12'h358 |=> rd_byte_o == 8'hFF)
      else $error("reserved byte not all ones");
   a_reserved_run: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      rd_req_i && rd_addr_i == 12'h350 |=> rd_word_o[31:8] == 24'hFFFFFF)
      else $error("reserved run not all ones");
   a_dual_all_fields: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      rd_req_i && rd_addr_i == 12'h354
      |=> rd_word_o[23:21] == 3'b111 && rd_word_o[20:16] == 5'b11111
      && rd_word_o[31:24] == 8'hFF)
      else $error("dual all fields not all ones");
   a_quad_all_code: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      rd_req_i && rd_addr_i == 12'h35B |=> rd_byte_o == 8'hEB)
      else $error("quad all code wrong");
   // granule size is two raised to the stored exponent
   a_size_small: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      rd_req_i && rd_addr_i == 12'h35C
      |=> (32'h00000001 << rd_byte_o) == 32'h00001000)
      else $error("first granule size wrong");
   a_size_half: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      rd_req_i && rd_addr_i == 12'h35E
      |=> (32'h00000001 << rd_byte_o) == 32'h00008000)
      else $error("second granule size wrong");
   a_size_block: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      rd_req_i && rd_addr_i == 12'h360
      |=> (32'h00000001 << rd_byte_o) == 32'h00010000)
      else $error("third granule size wrong");
   // erase exponents and instructions
   a_erase_one_exp: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      rd_req_i && rd_addr_i == 12'h35C |=> rd_byte_o == 8'h0C)
      else $error("first erase exponent wrong");
   a_erase_one_cmd: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      rd_req_i && rd_addr_i == 12'h35D |=> rd_byte_o == 8'h20)
      else $error("first erase code wrong");
   a_erase_two_exp: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      rd_req_i && rd_addr_i == 12'h35E |=> rd_byte_o == 8'h0F)
      else $error("second erase exponent wrong");
   a_erase_two_cmd: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      rd_req_i && rd_addr_i == 12'h35F |=> rd_byte_o == 8'h52)
      else $error("second erase code wrong");
   a_erase_three_exp: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      rd_req_i && rd_addr_i == 12'h360 |=> rd_byte_o == 8'h10)
      else $error("third erase exponent wrong");
   a_erase_three_cmd: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      rd_req_i && rd_addr_i == 12'h361 |=> rd_byte_o == 8'hD8)
      else $error("third erase code wrong");
   a_erase_four_exp: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      rd_req_i && rd_addr_i == 12'h362 |=> rd_byte_o == 8'h00)
      else $error("fourth erase exponent wrong");
   a_erase_last: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      rd_req_i && rd_addr_i == 12'h360 |=> rd_word_o == 32'hFF00D810)
      else $error("erase word two wrong");

   // ----------------------------------------
   // checks on word assembly
   // ----------------------------------------
   // lowest relative byte lands in bits 7:0
   a_dual_out_word: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      rd_req_i && rd_addr_i == 12'h34C |=> rd_word_o == 32'hBB883B08)
      else $error("dual word wrong");
   a_dual_io_fields: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      rd_req_i && rd_addr_i == 12'h34C
      |=> rd_word_o[23:21] == 3'b100 && rd_word_o[20:16] == 5'b01000)
      else $error("dual io word fields wrong");
   a_quad_all_word: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      rd_req_i && rd_addr_i == 12'h358 |=> rd_word_o == 32'hEB48FFFF)
      else $error("quad all word wrong");
   a_quad_all_fields: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      rd_req_i && rd_addr_i == 12'h358
      |=> rd_word_o[23:21] == 3'b010 && rd_word_o[20:16] == 5'b01000)
      else $error("quad all word fields wrong");
   a_erase_word: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      rd_req_i && rd_addr_i == 12'h35C |=> rd_word_o == 32'h520F200C)
      else $error("erase word order wrong");

   // ----------------------------------------
   // checks on the address span
   // ----------------------------------------
   // hits only from base plus 0Ch to base plus 23h
   a_base_miss: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      rd_req_i && rd_addr_i == 12'h04C |=> !rd_hit_o && rd_byte_o == 8'h00)
      else $error("address outside table hit");
   a_page_miss: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      rd_req_i && rd_addr_i == 12'h44C |=> !rd_hit_o && rd_byte_o == 8'h00)
      else $error("address one page above table hit");
   a_span_first: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      rd_req_i && rd_addr_i == 12'h34C |=> rd_hit_o)
      else $error("first span byte missed");
   a_span_below: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      rd_req_i && rd_addr_i == 12'h34B
      |=> !rd_hit_o && rd_word_o == 32'h00000000)
      else $error("byte below span hit");
   a_span_above: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      rd_req_i && rd_addr_i == 12'h364 |=> !rd_hit_o && rd_byte_o == 8'h00)
      else $error("byte above span hit");

endmodule

// [verification/sbpr_host_model.sv]
// host side model issuing parameter table reads
`timescale 1ns/1ps
module sbpr_host_model (
   input  wire logic        clk_sys_i,
   input  wire logic        issue_i,
   input  wire logic [11:0] addr_i,
   output logic             rd_req_o,
   output logic [11:0]      rd_addr_o
);
   logic [11:0] idle_addr = 12'hA5A;
   // idle address changes every cycle so nothing stale reads as valid
   always @(posedge clk_sys_i) idle_addr <= ~idle_addr;
   assign rd_req_o  = issue_i;
   assign rd_addr_o = issue_i ? addr_i : idle_addr;
endmodule

// [verification/test_sbpr_rom.sv]
// self-checking bench for the parameter table slice
`timescale 1ns/1ps
module test_sbpr_rom;
   logic        clk_sys_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        issue = 1'b0;
   logic [11:0] addr = 12'h000;
   logic        rd_req_i, rd_valid_o, rd_hit_o;
   logic [11:0] rd_addr_i;
   logic [7:0]  rd_byte_o;
   logic [31:0] rd_word_o;
   int          bad_count = 0;
   int          comparisons = 0;
   logic [11:0] pend[$];
   logic [7:0]  tbl [0:23] = '{8'h08, 8'h3B, 8'h88, 8'hBB, 8'hFE, 8'hFF,
      8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h48, 8'hEB,
      8'h0C, 8'h20, 8'h0F, 8'h52, 8'h10, 8'hD8, 8'h00, 8'hFF};
   always #5 clk_sys_i = ~clk_sys_i;
   sbpr_host_model sbpr_host_model_inst (.clk_sys_i(clk_sys_i),
      .issue_i(issue), .addr_i(addr), .rd_req_o(rd_req_i),
      .rd_addr_o(rd_addr_i));
   sbpr_rom sbpr_rom_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
      .rd_req_i(rd_req_i), .rd_addr_i(rd_addr_i), .rd_valid_o(rd_valid_o),
      .rd_hit_o(rd_hit_o), .rd_byte_o(rd_byte_o), .rd_word_o(rd_word_o));
   // reference: relative offset from base, 00h outside the span
   function automatic logic ref_hit(logic [11:0] a);
      return (a - 12'h340) >= 12'h00C && (a - 12'h340) <= 12'h023;
   endfunction
   function automatic logic [7:0] ref_byte(logic [11:0] a);
      return ref_hit(a) ? tbl[a - 12'h34C] : 8'h00;
   endfunction
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic tally_and_finish();
      $display("compared %0d mismatched %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // one cycle: check the answer to last request, then drive the next
   task automatic step(logic go, logic [11:0] a);
      logic [11:0] p;
      @(negedge clk_sys_i);
      chk("valid", {31'h0, pend.size() != 0}, {31'h0, rd_valid_o});
      if (pend.size() != 0) begin
         p = pend.pop_front();
         chk("hit", {31'h0, ref_hit(p)}, {31'h0, rd_hit_o});
         chk("byte", {24'h0, ref_byte(p)}, {24'h0, rd_byte_o});
         chk("word", {ref_byte({p[11:2], 2'h3}), ref_byte({p[11:2], 2'h2}),
            ref_byte({p[11:2], 2'h1}), ref_byte({p[11:2], 2'h0})},
            rd_word_o);
      end
      if (go) pend.push_back(a);
      issue = go;
      addr = a;
   endtask
   initial begin
      #50000;
      bad_count++;
      tally_and_finish();
   end
   initial begin
      void'($urandom(32'h3C6972EB));
      repeat (4) @(negedge clk_sys_i);
      chk("reset out", 32'h0, {rd_byte_o, 21'h0, rd_valid_o, rd_hit_o,
         |rd_word_o});
      rst_i = 1'b0;
      // back to back sweep across both span edges
      for (int a = 32'h338; a <= 32'h368; a++) step(1'b1, a[11:0]);
      $display("sweep test done");
      // random gaps and addresses around the table
      repeat (400) step(1'($urandom_range(1, 0)),
         12'(32'h300 + $urandom_range(32'h7F, 0)));
      $display("random test done");
      // far below the base and one page above it, then a table byte and an idle step
      step(1'b1, 12'h04C);
      step(1'b1, 12'h44C);
      step(1'b1, 12'h35C);
      step(1'b0, 12'h000);
      $display("miss test done");
      // mid-run reset clears the held answer
      rst_i = 1'b1;
      @(negedge clk_sys_i);
      chk("mid reset", 32'h0, {rd_byte_o, 21'h0, rd_valid_o, rd_hit_o,
         |rd_word_o});
      rst_i = 1'b0;
      step(1'b0, 12'h000);
      step(1'b0, 12'h000);
      $display("reset test done");
      tally_and_finish();
   end
endmodule
